// [verilog/blt_pkg.sv]
// package: constants and encodings for the burst laser transmit control block
// Overview of operation
// (R1) modulation dac follows host value, or reloads from modulation table every 10 ms
// (R2) modulation table read from eeprom slave A6h, bytes 80h-FFh, temperature indexed
// (R3) modulation ramp moves one lsb per clock, otherwise new value applies at once
// (R4) bias ramp moves one lsb per clock, otherwise new value applies at once
// (R5) modulation current off between bursts and during safety shutdown
// (R6) burst gate inversion control and separate transmit polarity inversion control
// (R7) eye crossing shift by direction and size, hires halves step and range
// (R8) light detect high when laser emits light, judged by photodiode comparator
// (R9) light in burst gaps flagged as rogue emission fault to safety logic
// (R10) in gaps comparator goes straight to light detect and rogue logic
// (R11) rogue testing suppressed for programmable cycles after burst gate falls
// (R12) in burst light detect latches high, clears at burst end or deglitch timeout
// (R13) light detect forced high while fast start runs
// (R14) select picks detect or fault pin function, allow holds pin high until config
// (R15) light detect reasserts whenever light returns within a burst
// (R16) three-bit bias mode selects open, lut, closed, preload, fast start modes
// (R17) mode bit0 lut enable, bit1 fast start enable, bit2 closed loop enable
// (R18) bias dac set by host; open loop with lut reloads every 10 ms
// (R19) bias table read from eeprom slave A6h, bytes 00h-7Fh, temperature indexed
// (R20) closed loop adds gain-scaled power error into precise bias accumulator
// (R21) closed loop lut and fast start bits act once then clear; host may retrigger
// (R22) mode loaded at power up; sleep and disable copy preset bits into mode
// (R23) deglitch counted in clock cycles, restarting whenever comparator returns high
package blt_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LUT_REFRESH_NS = 10_000_000;
    localparam int LUT_REFRESH_CYC = LUT_REFRESH_NS / CLK_PERIOD_NS;
    // eeprom table location
    localparam logic [7:0] EEP_SLAVE = 8'hA6;
    localparam logic [7:0] MODLUT_BASE = 8'h80;
    localparam logic [7:0] BIASLUT_BASE = 8'h00;
    // register offsets
    localparam logic [7:0] OFS_MODDAC = 8'h00;
    localparam logic [7:0] OFS_BIASDAC = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_BIASMODE = 8'h0C;
    localparam logic [7:0] OFS_PWSIZE = 8'h10;
    localparam logic [7:0] OFS_DEGLITCH = 8'h14;
    localparam logic [7:0] OFS_ROGUE_DLY = 8'h18;
    localparam logic [7:0] OFS_APC = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    // control register fields
    localparam int CTRL_MODLUT = 0;
    localparam int CTRL_MODRAMP = 1;
    localparam int CTRL_BIASRAMP = 2;
    localparam int CTRL_BURST_INV = 3;
    localparam int CTRL_TX_INV = 4;
    localparam int CTRL_PW_DIR = 5;
    localparam int CTRL_PW_HIRES = 6;
    localparam int CTRL_SD_SELECT = 7;
    localparam int CTRL_SD_ALLOW = 8;
    // bias mode register fields, apc register gain field lsb and bias accumulator fraction bits
    localparam int BM_LUT = 0;
    localparam int BM_FS = 1;
    localparam int BM_APC = 2;
    localparam int BM_FS_SLEEP = 3;
    localparam int BM_LUT_SLEEP = 4;
    localparam int BM_FS_TXDIS = 5;
    localparam int BM_LUT_TXDIS = 6;
    localparam int APC_GAIN_LSB = 8;
    localparam int APC_FRAC = 15;
    // reset values
    localparam logic [8:0] CTRL_RST = 9'h100;
    localparam logic [6:0] BIASMODE_RST = 7'h00;
    localparam logic [15:0] DEGLITCH_RST = 16'h0010;
    localparam logic [15:0] ROGUE_DLY_RST = 16'h0040;
    localparam logic [3:0] APC_GAIN_RST = 4'h8;
    // table fetch states
    typedef enum logic [2:0] {
        BLT_IDLE = 3'b001,
        BLT_MOD = 3'b010,
        BLT_BIAS = 3'b100
    } blt_fetch_t;
endpackage : blt_pkg

// [verilog/blt_control.sv]
// module: burst laser transmit control, dacs, bias modes, light detect, rogue
`timescale 1ns/100ps
module blt_control #(
    parameter int REFRESH_CYC = blt_pkg::LUT_REFRESH_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic burst_gate,
    input wire logic light_cmp,
    input wire logic safety_shutdown,
    input wire logic safety_fault,
    input wire logic [7:0] temp_uncal,
    input wire logic [7:0] mon_power,
    input wire logic cfg_done,
    input wire logic [2:0] boot_biasmode,
    input wire logic sleep_in,
    input wire logic tx_disable_in,
    input wire logic eep_done,
    input wire logic [7:0] eep_data,
    input wire logic fs_done,
    input wire logic [7:0] fs_bias,
    output logic [7:0] mod_dac,
    output logic mod_enable,
    output logic [7:0] bias_dac,
    output logic tx_invert_out,
    output logic eye_dir,
    output logic [3:0] eye_size,
    output logic eye_hires,
    output logic light_detect_internal,
    output logic rogue_fault,
    output logic light_detect_out,
    output logic light_detect_oe,
    output logic eep_req,
    output logic [7:0] eep_dev,
    output logic [7:0] eep_addr,
    output logic fs_active
);
    typedef struct packed {
        logic [7:0] mod_tgt;
        logic [7:0] mod_out;
        logic mod_on;
        logic [22:0] bias_acc;
        logic [7:0] bias_out;
        logic [8:0] ctrl;
        logic [6:0] bmode;
        logic [3:0] pw_size;
        logic [15:0] dg_period;
        logic [15:0] rg_delay;
        logic [15:0] dg_cnt;
        logic [15:0] rg_cnt;
        logic [7:0] apc_target;
        logic [3:0] apc_gain;
        logic burst_q;
        logic sleep_q;
        logic txdis_q;
        logic cfg_q;
        logic sd_int;
        logic rogue;
        logic pin_o;
        logic pin_oe;
        logic [31:0] tick_cnt;
        logic mod_pend;
        logic bias_pend;
        blt_pkg::blt_fetch_t fsm;
        logic eep_req;
        logic [7:0] eep_dev;
        logic [7:0] eep_addr;
        logic fs_active;
        logic [31:0] rdata;
    } blt_state_t;

    blt_state_t st_reg;
    blt_state_t st_next;
    logic burst_eff;
    logic burst_fall;
    logic tick;
    logic apc_on;
    logic [8:0] apc_err;
    logic [24:0] apc_delta;
    logic [24:0] apc_sum;

    // step toward target by one lsb, or jump when ramp is off
    function automatic logic [7:0] blt_step(input logic [7:0] cur, input logic [7:0] tgt,
                                            input logic ramp);
        logic [7:0] res;
        res = tgt;
        if (ramp && cur < tgt) begin
            res = cur + 8'h01;
        end else if (ramp && cur > tgt) begin
            res = cur - 8'h01;
        end
        return res;
    endfunction : blt_step

    // effective burst gate and shared timing terms
    // (R6) gate inversion
    assign burst_eff = burst_gate ^ st_reg.ctrl[blt_pkg::CTRL_BURST_INV];
    assign burst_fall = st_reg.burst_q & ~burst_eff;
    // (R1) (R18) refresh period tick
    assign tick = (st_reg.tick_cnt >= REFRESH_CYC - 1);
    // (R16) (R17) mode bit decode
    assign apc_on = st_reg.bmode[blt_pkg::BM_APC];
    // (R20) gain-scaled power error
    assign apc_err = {1'b0, st_reg.apc_target} - {1'b0, mon_power};
    assign apc_delta = 25'($signed({{16{apc_err[8]}}, apc_err}) <<< st_reg.apc_gain);
    assign apc_sum = {2'b00, st_reg.bias_acc} + apc_delta;

    // next state of the whole block
    always_comb begin
        st_next = st_reg;
        st_next.rdata = 32'h0000_0000;
        st_next.burst_q = burst_eff;
        st_next.sleep_q = sleep_in;
        st_next.txdis_q = tx_disable_in;
        st_next.cfg_q = cfg_done;
        st_next.tick_cnt = tick ? 32'h0000_0000 : st_reg.tick_cnt + 32'h0000_0001;

        // (R5) modulation gated by burst and shutdown
        st_next.mod_on = burst_eff & ~safety_shutdown;
        // (R3) modulation ramp or direct
        st_next.mod_out = blt_step(st_reg.mod_out, st_reg.mod_tgt,
                                   st_reg.ctrl[blt_pkg::CTRL_MODRAMP]);
        // (R4) bias ramp or direct
        st_next.bias_out = blt_step(st_reg.bias_out, st_reg.bias_acc[22:blt_pkg::APC_FRAC],
                                    st_reg.ctrl[blt_pkg::CTRL_BIASRAMP]);

        // (R1) periodic modulation table refresh
        if (tick && st_reg.ctrl[blt_pkg::CTRL_MODLUT]) begin
            st_next.mod_pend = 1'b1;
        end
        // (R18) open loop bias table refresh
        if (tick && !apc_on && st_reg.bmode[blt_pkg::BM_LUT]) begin
            st_next.bias_pend = 1'b1;
        end

        // (R20) closed loop accumulation during bursts
        if (apc_on && burst_eff && !st_reg.fs_active && st_reg.fsm == blt_pkg::BLT_IDLE) begin
            if (apc_sum[24]) begin
                st_next.bias_acc = 23'h000000;
            end else if (apc_sum[23]) begin
                st_next.bias_acc = 23'h7FFFFF;
            end else begin
                st_next.bias_acc = apc_sum[22:0];
            end
        end

        // (R21) closed loop preload trigger, then clear the bit
        if (apc_on && st_reg.bmode[blt_pkg::BM_LUT] && !st_reg.bias_pend
            && st_reg.fsm != blt_pkg::BLT_BIAS) begin
            st_next.bias_pend = 1'b1;
            st_next.bmode[blt_pkg::BM_LUT] = 1'b0;
        end
        // (R21) fast start once preload is done, then clear the bit
        if (apc_on && st_reg.bmode[blt_pkg::BM_FS] && !st_reg.fs_active && burst_eff
            && !st_reg.bias_pend && !st_reg.bmode[blt_pkg::BM_LUT]
            && st_reg.fsm == blt_pkg::BLT_IDLE) begin
            st_next.fs_active = 1'b1;
            st_next.bmode[blt_pkg::BM_FS] = 1'b0;
        end else if (st_reg.fs_active && fs_done) begin
            st_next.fs_active = 1'b0;
            st_next.bias_acc = {fs_bias, 15'h0000};
        end

        // table fetch sequencer, one entry at a time
        case (st_reg.fsm)
            blt_pkg::BLT_IDLE: begin
                if (st_reg.mod_pend) begin
                    // (R2) modulation entry address
                    st_next.fsm = blt_pkg::BLT_MOD;
                    st_next.mod_pend = 1'b0;
                    st_next.eep_req = 1'b1;
                    st_next.eep_dev = blt_pkg::EEP_SLAVE;
                    st_next.eep_addr = blt_pkg::MODLUT_BASE | {1'b0, temp_uncal[7:1]};
                end else if (st_reg.bias_pend && !st_reg.fs_active) begin
                    // (R19) bias entry address
                    st_next.fsm = blt_pkg::BLT_BIAS;
                    st_next.bias_pend = 1'b0;
                    st_next.eep_req = 1'b1;
                    st_next.eep_dev = blt_pkg::EEP_SLAVE;
                    st_next.eep_addr = blt_pkg::BIASLUT_BASE | {1'b0, temp_uncal[7:1]};
                end
            end
            blt_pkg::BLT_MOD: begin
                if (eep_done) begin
                    st_next.fsm = blt_pkg::BLT_IDLE;
                    st_next.eep_req = 1'b0;
                    st_next.mod_tgt = eep_data;
                end
            end
            blt_pkg::BLT_BIAS: begin
                if (eep_done) begin
                    st_next.fsm = blt_pkg::BLT_IDLE;
                    st_next.eep_req = 1'b0;
                    st_next.bias_acc = {eep_data, 15'h0000};
                end
            end
            default: begin
                st_next.fsm = blt_pkg::BLT_IDLE;
                st_next.eep_req = 1'b0;
            end
        endcase

        // (R12) in-burst latch with deglitch, (R23) counter restarts on light
        if (burst_eff) begin
            if (light_cmp) begin
                st_next.dg_cnt = 16'h0000;
                // (R15) reassert on returning light
                st_next.sd_int = 1'b1;
            end else if (st_reg.sd_int) begin
                if (st_reg.dg_cnt >= st_reg.dg_period) begin
                    st_next.sd_int = 1'b0;
                end else begin
                    st_next.dg_cnt = st_reg.dg_cnt + 16'h0001;
                end
            end
        end else begin
            // (R10) transparent in gaps
            st_next.dg_cnt = 16'h0000;
            st_next.sd_int = light_cmp;
        end
        // (R13) forced high during fast start
        if (st_reg.fs_active) begin
            st_next.sd_int = 1'b1;
        end

        // (R11) rogue test held off after burst end
        if (burst_fall) begin
            st_next.rg_cnt = st_reg.rg_delay;
        end else if (st_reg.rg_cnt != 16'h0000) begin
            st_next.rg_cnt = st_reg.rg_cnt - 16'h0001;
        end
        // (R9) light in gap reported to safety
        st_next.rogue = ~burst_eff & ~burst_fall & light_cmp & (st_reg.rg_cnt == 16'h0000);

        // (R14) pin function and start-up hold
        if (st_reg.ctrl[blt_pkg::CTRL_SD_ALLOW] && !cfg_done) begin
            st_next.pin_o = 1'b1;
            st_next.pin_oe = ~st_reg.ctrl[blt_pkg::CTRL_SD_SELECT];
        end else if (st_reg.ctrl[blt_pkg::CTRL_SD_SELECT]) begin
            st_next.pin_o = 1'b0;
            st_next.pin_oe = ~safety_fault;
        end else begin
            // (R8) light indication on pin
            st_next.pin_o = st_reg.sd_int;
            st_next.pin_oe = 1'b1;
        end

        // (R22) power-up mode load and preset copies
        if (cfg_done && !st_reg.cfg_q) begin
            st_next.bmode[2:0] = boot_biasmode;
        end
        if (sleep_in && !st_reg.sleep_q) begin
            st_next.bmode[blt_pkg::BM_FS] = st_reg.bmode[blt_pkg::BM_FS_SLEEP];
            st_next.bmode[blt_pkg::BM_LUT] = st_reg.bmode[blt_pkg::BM_LUT_SLEEP];
        end
        if (tx_disable_in && !st_reg.txdis_q) begin
            st_next.bmode[blt_pkg::BM_FS] = st_reg.bmode[blt_pkg::BM_FS_TXDIS];
            st_next.bmode[blt_pkg::BM_LUT] = st_reg.bmode[blt_pkg::BM_LUT_TXDIS];
        end

        // register writes, last so the host retrigger always lands
        if (reg_wr) begin
            case (reg_addr)
                blt_pkg::OFS_MODDAC: st_next.mod_tgt = reg_wdata[7:0];
                blt_pkg::OFS_BIASDAC: st_next.bias_acc = {reg_wdata[7:0], 15'h0000};
                blt_pkg::OFS_CTRL: st_next.ctrl = reg_wdata[8:0];
                blt_pkg::OFS_BIASMODE: st_next.bmode = reg_wdata[6:0];
                blt_pkg::OFS_PWSIZE: st_next.pw_size = reg_wdata[3:0];
                blt_pkg::OFS_DEGLITCH: st_next.dg_period = reg_wdata[15:0];
                blt_pkg::OFS_ROGUE_DLY: st_next.rg_delay = reg_wdata[15:0];
                blt_pkg::OFS_APC: begin
                    st_next.apc_target = reg_wdata[7:0];
                    st_next.apc_gain = reg_wdata[11:blt_pkg::APC_GAIN_LSB];
                end
                default: begin
                end
            endcase
        end
        // register reads, data one cycle later
        if (reg_rd) begin
            case (reg_addr)
                blt_pkg::OFS_MODDAC: st_next.rdata = {24'h000000, st_reg.mod_tgt};
                blt_pkg::OFS_BIASDAC: st_next.rdata = {24'h000000, st_reg.bias_out};
                blt_pkg::OFS_CTRL: st_next.rdata = {23'h000000, st_reg.ctrl};
                blt_pkg::OFS_BIASMODE: st_next.rdata = {25'h0000000, st_reg.bmode};
                blt_pkg::OFS_PWSIZE: st_next.rdata = {28'h0000000, st_reg.pw_size};
                blt_pkg::OFS_DEGLITCH: st_next.rdata = {16'h0000, st_reg.dg_period};
                blt_pkg::OFS_ROGUE_DLY: st_next.rdata = {16'h0000, st_reg.rg_delay};
                blt_pkg::OFS_APC: begin
                    st_next.rdata = {20'h00000, st_reg.apc_gain, st_reg.apc_target};
                end
                blt_pkg::OFS_STATUS: begin
                    st_next.rdata = {27'h0000000, st_reg.burst_q,
                                     st_reg.mod_pend | st_reg.bias_pend,
                                     st_reg.fs_active, st_reg.rogue, st_reg.sd_int};
                end
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.ctrl <= blt_pkg::CTRL_RST;
            st_reg.bmode <= blt_pkg::BIASMODE_RST;
            st_reg.dg_period <= blt_pkg::DEGLITCH_RST;
            st_reg.rg_delay <= blt_pkg::ROGUE_DLY_RST;
            st_reg.apc_gain <= blt_pkg::APC_GAIN_RST;
            st_reg.fsm <= blt_pkg::BLT_IDLE;
            st_reg.pin_o <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from state flops
    assign reg_rdata = st_reg.rdata;
    assign mod_dac = st_reg.mod_out;
    assign mod_enable = st_reg.mod_on;
    assign bias_dac = st_reg.bias_out;
    // (R6) transmit polarity, (R7) eye crossing controls
    assign tx_invert_out = st_reg.ctrl[blt_pkg::CTRL_TX_INV];
    assign eye_dir = st_reg.ctrl[blt_pkg::CTRL_PW_DIR];
    assign eye_size = st_reg.pw_size;
    assign eye_hires = st_reg.ctrl[blt_pkg::CTRL_PW_HIRES];
    assign light_detect_internal = st_reg.sd_int;
    assign rogue_fault = st_reg.rogue;
    assign light_detect_out = st_reg.pin_o;
    assign light_detect_oe = st_reg.pin_oe;
    assign eep_req = st_reg.eep_req;
    assign eep_dev = st_reg.eep_dev;
    assign eep_addr = st_reg.eep_addr;
    assign fs_active = st_reg.fs_active;

    // checks on the design's own outputs
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    mod_off_a: assert property (!burst_eff || safety_shutdown |=> !mod_enable) // R5
        else $error("modulation on outside burst or in shutdown");
    mod_ramp_a: assert property (st_reg.ctrl[1] && mod_dac != st_reg.mod_tgt |=> // R3
        mod_dac == $past(mod_dac) + 8'h01 || mod_dac == $past(mod_dac) - 8'h01)
        else $error("modulation ramp step not one lsb");
    mod_direct_a: assert property (!st_reg.ctrl[1] |=> mod_dac == $past(st_reg.mod_tgt)) // R3
        else $error("modulation value not applied at once");
    bias_ramp_a: assert property (st_reg.ctrl[2] && bias_dac != st_reg.bias_acc[22:15] |=> // R4
        bias_dac == $past(bias_dac) + 8'h01 || bias_dac == $past(bias_dac) - 8'h01)
        else $error("bias ramp step not one lsb");
    gap_pass_a: assert property (!burst_eff && !fs_active |=> // R10
        light_detect_internal == $past(light_cmp))
        else $error("gap detect not transparent");
    burst_latch_a: assert property (burst_eff && light_cmp ##1 burst_eff && !light_cmp |-> // R12
        light_detect_internal)
        else $error("burst detect not latched");
    fs_force_a: assert property (fs_active |=> light_detect_internal) // R13
        else $error("detect not forced during fast start");
    rogue_hold_a: assert property (st_reg.rg_cnt != 16'h0000 |=> !rogue_fault) // R11
        else $error("rogue fault during hold-off");
    mod_addr_a: assert property (eep_req && st_reg.fsm == blt_pkg::BLT_MOD |-> // R2
        eep_addr[7] && eep_dev == blt_pkg::EEP_SLAVE)
        else $error("bad modulation table address");
    allow_hold_a: assert property (st_reg.ctrl[8] && !cfg_done |=> // R14
        light_detect_out || !light_detect_oe)
        else $error("pin not held high before config");

    burst_detect_c: cover property (burst_eff && light_cmp ##1 light_detect_internal);
    rogue_seen_c: cover property (rogue_fault);
    lut_fetch_c: cover property (eep_req ##[1:20] !eep_req);
    fast_start_c: cover property ($rose(fs_active) ##[1:50] $fell(fs_active));
    pin_fault_c: cover property (st_reg.ctrl[blt_pkg::CTRL_SD_SELECT] && !light_detect_oe);
endmodule : blt_control

// [verification/blt_far_model.sv]
// far side model: eeprom byte reader and fast start engine
`timescale 1ns/100ps
module blt_far_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic eep_req,
    input wire logic [7:0] eep_addr,
    input wire logic fs_active,
    output logic eep_done,
    output logic [7:0] eep_data,
    output logic fs_done,
    output logic [7:0] fs_bias
);
    int ecnt;
    int fcnt;
    // odd addresses answer slowly, even ones promptly; data inverts every cycle off the done cycle
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            eep_done <= 1'b0;
            eep_data <= 8'h00;
            fs_done <= 1'b0;
            fs_bias <= 8'h00;
            ecnt <= 0;
            fcnt <= 0;
        end else begin
            eep_data <= ~eep_data;
            fs_bias <= ~fs_bias;
            eep_done <= 1'b0;
            fs_done <= 1'b0;
            ecnt <= 0;
            fcnt <= 0;
            if (!eep_done && eep_req) begin
                ecnt <= ecnt + 1;
                if (ecnt == (eep_addr[0] ? 12 : 1)) begin
                    eep_done <= 1'b1;
                    eep_data <= eep_addr ^ 8'hA5;
                end
            end
            if (!fs_done && fs_active) begin
                fcnt <= fcnt + 1;
                if (fcnt == 10) begin
                    fs_done <= 1'b1;
                    fs_bias <= 8'h3C;
                end
            end
        end
    end
endmodule : blt_far_model

// [verification/testbench.sv]
// self-checking bench for the burst laser transmit control block
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, burst_gate = 0, light_cmp = 0;
    logic safety_shutdown = 0, cfg_done = 0, eep_done, fs_done, mod_enable, tx_invert_out;
    logic eye_dir, light_detect_internal, rogue_fault, eep_req, fs_active, last;
    logic [7:0] reg_addr = 0, temp_uncal = 0, eep_data, fs_bias, mod_dac, bias_dac;
    logic [7:0] eep_dev, eep_addr;
    logic safety_fault = 0, eye_hires, light_detect_out, light_detect_oe;
    logic [2:0] boot_biasmode = 3'b001;
    logic [3:0] eye_size;
    logic [31:0] reg_wdata = 0, reg_rdata, d;
    int seed = 9, bad_count = 0, checks = 0, cyc = 0, i;
    // clock
    initial forever #5 clk_sys = ~clk_sys;
    blt_control #(.REFRESH_CYC(50)) blt_control_inst (.clk_sys, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .burst_gate, .light_cmp, .safety_shutdown,
        .safety_fault, .temp_uncal, .mon_power(8'h80), .cfg_done,
        .boot_biasmode, .sleep_in(1'b0), .tx_disable_in(1'b0), .eep_done, .eep_data,
        .fs_done, .fs_bias, .mod_dac, .mod_enable, .bias_dac, .tx_invert_out, .eye_dir,
        .eye_size, .eye_hires, .light_detect_internal, .rogue_fault,
        .light_detect_out, .light_detect_oe, .eep_req, .eep_dev, .eep_addr, .fs_active);
    blt_far_model blt_far_model_inst (.clk_sys, .sys_rst, .eep_req, .eep_addr, .fs_active,
        .eep_done, .eep_data, .fs_done, .fs_bias);
    function logic [7:0] eep_val(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction : eep_val
    task tally_and_finish;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task chk(input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    // write a dac and count cycles until it lands
    task ramp(input logic [7:0] a, v, input int lo);
        int n;
        wr(a, {24'h0, v});
        for (n = 0; n < 600 && (a == 8'h00 ? mod_dac : bias_dac) !== v; n++) tick(1);
        if (lo >= 0) chk(n >= lo && n <= lo + 3, 1);
    endtask : ramp
    // one table fetch after a fresh temperature
    task lut_run(input logic is_mod);
        logic [7:0] a;
        for (i = 0; i < 300 && eep_done !== 1'b1; i++) tick(1);
        @(posedge clk_sys);
        temp_uncal <= 8'($random(seed));
        tick(1);
        for (i = 0; i < 300 && eep_req !== 1'b1; i++) tick(1);
        a = {is_mod, temp_uncal[7:1]};
        chk(eep_dev, 8'hA6);
        chk(eep_addr, a);
        for (i = 0; i < 40 && eep_done !== 1'b1; i++) tick(1);
        tick(3);
        chk(is_mod ? mod_dac : bias_dac, eep_val(a));
    endtask : lut_run
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h08);
        chk(d, 32'h100);
        chk({light_detect_out, light_detect_oe}, 2'b11);
        cfg_done <= 1'b1;
        rd(8'h0C);
        chk(d, 32'h1);
        chk({light_detect_out, light_detect_oe}, 2'b01);
        wr(8'h0C, 32'h0);
        rd(8'h30);
        chk(d, 32'h0);
        d = $random(seed);
        wr(8'h10, d & 32'hF);
        wr(8'h08, 32'hF8);
        safety_fault <= 1'b1;
        tick(3);
        chk({tx_invert_out, eye_dir, mod_enable, eye_hires, eye_size}, {4'hF, d[3:0]});
        chk({light_detect_out, light_detect_oe}, 2'b00);
        safety_fault <= 1'b0;
        tick(2);
        chk({light_detect_out, light_detect_oe}, 2'b01);
        wr(8'h08, 32'h0);
        tick(3);
        chk(mod_enable, 1'b0);
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            wr(8'h00, d & 32'hFF);
            tick(3);
            chk(mod_dac, d[7:0]);
        end
        wr(8'h08, 32'h6);
        ramp(8'h00, 8'h00, -1);
        ramp(8'h00, 8'hC8, 199);
        ramp(8'h04, 8'h64, 99);
        wr(8'h08, 32'h1);
        repeat (2) lut_run(1'b1);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h1);
        repeat (2) lut_run(1'b0);
        wr(8'h0C, 32'h0);
        wr(8'h18, 32'd20);
        wr(8'h14, 32'd6);
        // gap: detect is transparent
        for (int k = 0; k < 12; k++) begin
            @(posedge clk_sys);
            last = light_cmp;
            light_cmp <= 1'($random(seed));
            #1 chk(light_detect_internal, last);
        end
        @(posedge clk_sys);
        burst_gate <= 1'b1;
        light_cmp <= 1'b1;
        tick(3);
        chk({light_detect_internal, mod_enable}, 2'b11);
        safety_shutdown <= 1'b1;
        light_cmp <= 1'b0;
        tick(4);
        chk({light_detect_internal, mod_enable}, 2'b10);
        safety_shutdown <= 1'b0;
        light_cmp <= 1'b1;
        tick(1);
        light_cmp <= 1'b0;
        tick(5);
        chk(light_detect_internal, 1'b1);
        tick(6);
        chk(light_detect_internal, 1'b0);
        light_cmp <= 1'b1;
        tick(2);
        chk(light_detect_internal, 1'b1);
        burst_gate <= 1'b0;
        tick(10);
        chk(rogue_fault, 1'b0);
        tick(15);
        chk(rogue_fault, 1'b1);
        light_cmp <= 1'b0;
        tick(3);
        chk({rogue_fault, light_detect_internal}, 2'b00);
        wr(8'h1C, 32'h880);
        burst_gate <= 1'b1;
        wr(8'h0C, 32'h6);
        for (i = 0; i < 40 && fs_active !== 1'b1; i++) tick(1);
        tick(2);
        chk({fs_active, light_detect_internal}, 2'b11);
        for (i = 0; i < 40 && fs_active !== 1'b0; i++) tick(1);
        tick(2);
        chk(bias_dac, 8'h3C);
        rd(8'h0C);
        chk(d[2:0], 3'b100);
        tally_and_finish;
    end
endmodule : testbench
